// ### inc/bst_pkg.sv
// Package for the buck switching timing and protection block.
// Assumes a 20 MHz pclk and an APB register bus with 32-bit data.
package bst_pkg;
    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_NS = 50;
    localparam int MIN_ON_NS = 120;
    localparam int LOCK_NS = 100000;
    localparam int FB_FREQ_KHZ = 150;
    localparam int SYNC_MIN_KHZ = 300;
    // Least time rounds up, longest time rounds down
    localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOCK_CYC = LOCK_NS / CLK_NS;
    localparam int FB_PER_CYC = (1000000 / FB_FREQ_KHZ) / CLK_NS;
    localparam int SYNC_MAX_PER_CYC = (1000000 / SYNC_MIN_KHZ) / CLK_NS;
    localparam int LOSS_CYC = 2 * SYNC_MAX_PER_CYC;
    localparam int SS_CYCLES = 1114;
    localparam int MAX_DIV = 8;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PERIOD_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] SSCNT_OFS = 8'h0c;
    localparam int CTRL_RUN_BIT = 0;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam logic [15:0] PERIOD_RST = 16'h0032;
    localparam int ST_PLL_BIT = 0;
    localparam int ST_LOCK_BIT = 1;
    localparam int ST_FB_BIT = 2;
    localparam int ST_OVP_BIT = 3;
    localparam int ST_TSD_BIT = 4;
    localparam int ST_SSDONE_BIT = 5;
    localparam int ST_DIV_LSB = 8;

    // ---------------------------------------------------------------
    // State types
    // ---------------------------------------------------------------
    typedef enum logic [2:0]
    {
        RUN_STOP = 3'b001,
        RUN_SOFT = 3'b010,
        RUN_FULL = 3'b100
    } bst_run_e;

    typedef enum logic [2:0]
    {
        MODE_RES = 3'b001,
        MODE_PLL = 3'b010,
        MODE_FB = 3'b100
    } bst_mode_e;
endpackage

// ### verilog/bst_core.sv
// Switching timing, frequency foldback, sync and protection for a buck.
// Assumes all comparator flags and the sync pin are synchronous to pclk.
//
// Contract
// R1 - High side off at current control level
// R2 - Clamped control level limits switch current
// R3 - Divide 8,4,2,1 as feedback rises
// R4 - Divide works in sync mode too
// R5 - High side on at least 120ns
// R6 - Sync cycle starts on clock falling edge
// R7 - External clock 300-1100kHz, phases over 40ns
// R8 - First sync high enters sync, source off
// R9 - Lock within 100 microseconds
// R10 - Accept sync faster or slower than resistor
// R11 - Leaving sync: 150kHz, then resistor rate
// R12 - Overvoltage blanks high side
// R13 - Overvoltage clear resumes without restart
// R14 - Thermal trip stops all switching
// R15 - Thermal recovery reruns slow start
// R16 - Slow start 1114 cycles, reset by enable/thermal
// R17 - Divide boundaries at quarter reference flags
// R18 - Comparator flags sampled before use
`timescale 1ns/1ps
module bst_core
#(
    parameter int PER_W = 16,
    parameter int FB_CYCLES = 8
)
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator flags
    input wire logic cur_trip,
    input wire logic ilim_trip,
    input wire logic overvoltage_guard,
    input wire logic thermal_trip,
    input wire logic en_ok,
    input wire logic [2:0] fb_quarter,
    // Timing and sync pin
    input wire logic timing_sync_pin,
    output logic src_en,
    // Power stage
    output logic hs_gate,
    output logic [10:0] ss_level
);
    import bst_pkg::*;

    // Elaboration check; the fallback period counter is four bits wide
    if (PER_W < 8 || PER_W > 16 || FB_CYCLES < 1 || FB_CYCLES > 16)
    begin : g_bad_param
        $error("bst_core: unsupported parameter values");
    end

    // ---------------------------------------------------------------
    // Input sampling
    // ---------------------------------------------------------------
    logic cur_q, ilim_q, ovp_q, tsd_q, en_q, sync_q, sync_d;
    logic [2:0] fbq_q;

    // Flags act only after one register stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_q <= 1'b0;
            ilim_q <= 1'b0;
            ovp_q <= 1'b0;
            tsd_q <= 1'b0;
            en_q <= 1'b0;
            fbq_q <= 3'h0;
            sync_q <= 1'b0;
            sync_d <= 1'b0;
        end
        else if (ce)
        begin
            cur_q <= cur_trip; // [R18]
            ilim_q <= ilim_trip;
            ovp_q <= overvoltage_guard;
            tsd_q <= thermal_trip;
            en_q <= en_ok;
            fbq_q <= fb_quarter;
            sync_q <= timing_sync_pin;
            sync_d <= sync_q;
        end
    end

    wire sync_rise = sync_q && !sync_d;
    wire sync_fall = !sync_q && sync_d;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic run_en_reg;
    logic [PER_W-1:0] period_reg;
    bst_run_e run_reg;
    bst_mode_e mode_reg;
    logic locked_reg;
    logic [10:0] ss_cnt_reg;
    logic [2:0] div_code;

    wire wr_acc = psel && penable && pready && pwrite;

    // Software control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_en_reg <= CTRL_RUN_RST;
            period_reg <= PER_W'(PERIOD_RST);
        end
        else if (ce && wr_acc)
        begin
            if (paddr == CTRL_OFS)
                run_en_reg <= pwdata[CTRL_RUN_BIT];
            else if (paddr == PERIOD_OFS)
                period_reg <= pwdata[PER_W-1:0];
        end
    end

    // Read mux, loaded in the setup cycle so data is steady in access
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [31:0] w;
        w = 32'h0;
        if (a == CTRL_OFS)
            w[CTRL_RUN_BIT] = run_en_reg;
        else if (a == PERIOD_OFS)
            w[PER_W-1:0] = period_reg;
        else if (a == STATUS_OFS)
        begin
            w[ST_PLL_BIT] = (mode_reg == MODE_PLL);
            w[ST_LOCK_BIT] = locked_reg;
            w[ST_FB_BIT] = (mode_reg == MODE_FB);
            w[ST_OVP_BIT] = ovp_q;
            w[ST_TSD_BIT] = tsd_q;
            w[ST_SSDONE_BIT] = (run_reg == RUN_FULL);
            w[ST_DIV_LSB +: 3] = div_code;
        end
        else if (a == SSCNT_OFS)
            w[10:0] = ss_cnt_reg;
        return w;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == CTRL_OFS || a == PERIOD_OFS || a == STATUS_OFS || a == SSCNT_OFS;
    endfunction

    // APB answer: no wait states, error on unmapped addresses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end
        else if (ce)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (psel && !penable)
                prdata <= rd_word(paddr);
        end
    end

    // ---------------------------------------------------------------
    // Timing source: resistor, sync, or fallback
    // ---------------------------------------------------------------
    logic [PER_W-1:0] osc_cnt;
    logic [11:0] mode_tmr;
    logic [3:0] fb_cnt;
    logic tick;

    // Period counter for resistor and fallback modes
    wire [PER_W-1:0] cur_per = (mode_reg == MODE_FB) ? PER_W'(FB_PER_CYC) : period_reg;
    wire osc_wrap = (osc_cnt >= cur_per - PER_W'(1));

    // Cycle start pulse; sync mode follows the pin edge directly
    always_comb
    begin
        if (mode_reg == MODE_PLL)
            tick = sync_fall; // [R6] [R10]
        else
            tick = osc_wrap;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_cnt <= '0;
        else if (ce)
        begin
            if (osc_wrap || mode_reg == MODE_PLL)
                osc_cnt <= '0;
            else
                osc_cnt <= osc_cnt + PER_W'(1);
        end
    end

    // Mode machine; clock loss leaves sync through a 150 kHz stretch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg <= MODE_RES;
            mode_tmr <= 12'h0;
            fb_cnt <= 4'h0;
            locked_reg <= 1'b0;
            src_en <= 1'b1;
        end
        else if (ce)
        begin
            case (mode_reg)
                MODE_RES:
                begin
                    if (sync_rise)
                    begin
                        mode_reg <= MODE_PLL; // [R8]
                        src_en <= 1'b0; // [R8]
                        mode_tmr <= 12'h0;
                        locked_reg <= 1'b0;
                    end
                end
                MODE_PLL:
                begin
                    // The first falling edge in time counts as locked
                    if (sync_fall)
                    begin
                        mode_tmr <= 12'h0;
                        locked_reg <= 1'b1; // [R9]
                    end
                    else
                        mode_tmr <= mode_tmr + 12'h1;
                    // A falling edge in the timeout cycle wins over the timeout
                    if (!sync_fall && ((locked_reg && mode_tmr >= 12'(LOSS_CYC))
                        || (!locked_reg && mode_tmr >= 12'(LOCK_CYC - 1))))
                    begin
                        mode_reg <= MODE_FB; // [R11] [R9]
                        locked_reg <= 1'b0;
                        fb_cnt <= 4'h0;
                    end
                end
                MODE_FB:
                begin
                    if (osc_wrap)
                        fb_cnt <= fb_cnt + 4'h1;
                    if (osc_wrap && fb_cnt >= 4'(FB_CYCLES - 1))
                    begin
                        mode_reg <= MODE_RES; // [R11]
                        src_en <= 1'b1; // [R11]
                    end
                end
                default:
                    mode_reg <= MODE_RES;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Frequency foldback
    // ---------------------------------------------------------------
    logic [2:0] div_cnt;

    // Quarter flags pick 8, 4, 2 or 1; count is digital so sync works
    always_comb
    begin
        if (fbq_q[2])
            div_code = 3'd0; // [R17] [R3]
        else if (fbq_q[1])
            div_code = 3'd1;
        else if (fbq_q[0])
            div_code = 3'd2;
        else
            div_code = 3'd3;
    end

    wire [2:0] div_mask = 3'((4'h1 << div_code) - 4'h1);
    wire sw_start = tick && ((div_cnt & div_mask) == 3'h0); // [R3] [R4]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= 3'h0;
        else if (ce && tick)
            div_cnt <= div_cnt + 3'h1;
    end

    // ---------------------------------------------------------------
    // Run state and slow start
    // ---------------------------------------------------------------
    wire halt = tsd_q || !en_q || !run_en_reg;

    // Any halt resets slow start; recovery starts it over from zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_reg <= RUN_STOP;
            ss_cnt_reg <= 11'h0;
        end
        else if (ce)
        begin
            case (run_reg)
                RUN_STOP:
                begin
                    ss_cnt_reg <= 11'h0; // [R16]
                    if (!halt)
                        run_reg <= RUN_SOFT; // [R15]
                end
                RUN_SOFT:
                begin
                    if (halt)
                    begin
                        run_reg <= RUN_STOP; // [R14] [R16]
                        ss_cnt_reg <= 11'h0; // [R16]
                    end
                    else if (sw_start)
                    begin
                        ss_cnt_reg <= ss_cnt_reg + 11'h1;
                        if (ss_cnt_reg >= 11'(SS_CYCLES - 1))
                            run_reg <= RUN_FULL; // [R16]
                    end
                end
                RUN_FULL:
                begin
                    // Count cleared with the halt, not a cycle later
                    if (halt)
                    begin
                        run_reg <= RUN_STOP; // [R14]
                        ss_cnt_reg <= 11'h0; // [R16]
                    end
                end
                default:
                    run_reg <= RUN_STOP;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ss_level <= 11'h0;
        else if (ce)
            ss_level <= ss_cnt_reg;
    end

    // ---------------------------------------------------------------
    // High-side pulse
    // ---------------------------------------------------------------
    logic [3:0] on_cnt;
    wire kill = ovp_q || halt || run_reg == RUN_STOP;
    wire min_done = (on_cnt >= 4'(MIN_ON_CYC - 1));
    wire trip = cur_q || ilim_q;

    // Overvoltage only blanks; run state is left alone so no restart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hs_gate <= 1'b0;
            on_cnt <= 4'h0;
        end
        else if (ce)
        begin
            if (kill)
                hs_gate <= 1'b0; // [R12] [R13] [R14]
            else if (hs_gate && trip && min_done)
                hs_gate <= 1'b0; // [R1] [R2] [R5]
            else if (sw_start && !hs_gate)
            begin
                hs_gate <= 1'b1;
                on_cnt <= 4'h0;
            end
            else if (hs_gate && !min_done)
                on_cnt <= on_cnt + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_trip_off;
        @(posedge pclk) disable iff (!presetn)
        ce && hs_gate && cur_q && min_done |=> !hs_gate;
    endproperty
    a_trip_off: assert property (p_trip_off) else $error("pulse not ended on trip"); // [R1]

    property p_ilim_off;
        @(posedge pclk) disable iff (!presetn)
        ce && hs_gate && ilim_q && min_done |=> !hs_gate;
    endproperty
    a_ilim_off: assert property (p_ilim_off) else $error("pulse not ended on limit"); // [R2]

    property p_min_on;
        @(posedge pclk) disable iff (!presetn)
        $fell(hs_gate) && !$past(kill) |-> $past(on_cnt) >= 4'(MIN_ON_CYC - 1);
    endproperty
    a_min_on: assert property (p_min_on) else $error("on-time below minimum"); // [R5]

    property p_div8;
        @(posedge pclk) disable iff (!presetn)
        ce && tick && fbq_q == 3'h0 && div_cnt[2:0] != 3'h0 |-> !sw_start;
    endproperty
    a_div8: assert property (p_div8) else $error("divide by 8 not applied"); // [R3]

    property p_sync_start;
        @(posedge pclk) disable iff (!presetn)
        ce && mode_reg == MODE_PLL && fbq_q[2] && sync_fall |-> sw_start;
    endproperty
    a_sync_start: assert property (p_sync_start) else $error("sync edge lost"); // [R6]

    property p_enter_pll;
        @(posedge pclk) disable iff (!presetn)
        ce && mode_reg == MODE_RES && sync_rise |=> mode_reg == MODE_PLL && !src_en;
    endproperty
    a_enter_pll: assert property (p_enter_pll) else $error("sync mode not entered"); // [R8]

    property p_fb_src;
        @(posedge pclk) disable iff (!presetn)
        mode_reg == MODE_FB |-> !src_en;
    endproperty
    a_fb_src: assert property (p_fb_src) else $error("source back too early"); // [R11]

    property p_lock_bound;
        @(posedge pclk) disable iff (!presetn)
        mode_reg == MODE_PLL && !locked_reg |-> mode_tmr < 12'(LOCK_CYC);
    endproperty
    a_lock_bound: assert property (p_lock_bound) else $error("lock wait too long"); // [R9]

    property p_ovp_off;
        @(posedge pclk) disable iff (!presetn)
        ce && ovp_q |=> !hs_gate;
    endproperty
    a_ovp_off: assert property (p_ovp_off) else $error("high side on in overvoltage"); // [R12]

    property p_ovp_norestart;
        @(posedge pclk) disable iff (!presetn)
        ce && ovp_q && !halt && run_reg == RUN_FULL |=> run_reg == RUN_FULL;
    endproperty
    a_ovp_norestart: assert property (p_ovp_norestart) else $error("restart on overvoltage"); // [R13]

    property p_tsd_stop;
        @(posedge pclk) disable iff (!presetn)
        ce && tsd_q |=> !hs_gate && run_reg == RUN_STOP && ss_cnt_reg == 11'h0 ##0 1'b1;
    endproperty
    a_tsd_stop: assert property (p_tsd_stop) else $error("switching during thermal trip"); // [R14]

    property p_ss_done;
        @(posedge pclk) disable iff (!presetn)
        $rose(run_reg == RUN_FULL) |-> ss_cnt_reg == 11'(SS_CYCLES);
    endproperty
    a_ss_done: assert property (p_ss_done) else $error("slow start length wrong"); // [R16]
endmodule

// ### test/bst_sync_src.sv
// External square-wave system clock that drives the timing and sync pin.
// Assumes the bench starts and stops it and sets its half period in pclk cycles.
`timescale 1ns/1ps
module bst_sync_src
(
    // Clock and reset
    pclk,
    presetn,
    // Control from the bench
    run,
    half,
    // Sync clock out
    clk_out
);
    input wire logic pclk;
    input wire logic presetn;
    input wire logic run;
    input wire logic [7:0] half;
    output logic clk_out;

    logic [7:0] cnt_reg;

    // -----------------------------------------------------------
    // Square wave
    // -----------------------------------------------------------
    // Half period of at least 1 cycle keeps each phase over 40ns
    // Idle low: the model drives the pin low while run is low or in reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn || !run)
        begin
            clk_out <= 1'b0;
            cnt_reg <= 8'h01;
        end
        else if (cnt_reg >= half)
        begin
            clk_out <= ~clk_out; // Period 2*half, kept within 300-1100 kHz
            cnt_reg <= 8'h01;
        end
        else
            cnt_reg <= cnt_reg + 8'h01;
    end
endmodule

// ### test/tb_top.sv
// Self-checking bench for the switching timing and protection block.
// Assumes bst_pkg, bst_core and the sync clock model are compiled first.
`timescale 1ns/1ps
module tb_top;
    import bst_pkg::*;
    localparam int FBN = 4;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, sync_half;
    logic [31:0] pwdata, prdata, rdv;
    logic cur_trip, ilim_trip, overvoltage_guard, thermal_trip, en_ok, erv;
    logic [2:0] fb_quarter;
    logic timing_sync_pin, src_en, hs_gate, sync_run, hs_q, pin_q;
    logic [10:0] ss_level;
    int n_fail, n_tests, n_rise, on_cnt, last_on, g;
    time rise_t, fall_t;

    bst_core #(.FB_CYCLES(FBN)) u_bst_core (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cur_trip(cur_trip),
        .ilim_trip(ilim_trip), .overvoltage_guard(overvoltage_guard),
        .thermal_trip(thermal_trip), .en_ok(en_ok), .fb_quarter(fb_quarter),
        .timing_sync_pin(timing_sync_pin), .src_en(src_en), .hs_gate(hs_gate),
        .ss_level(ss_level));
    bst_sync_src u_bst_sync_src (.pclk(pclk), .presetn(presetn), .run(sync_run),
        .half(sync_half), .clk_out(timing_sync_pin));

    // -----------------------------------------------------------
    // Clock, monitor and helpers
    // -----------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // Edge times of the gate and the sync pin, sampled at each rising edge
    always @(posedge pclk)
    begin
        if (hs_gate === 1'b1 && hs_q !== 1'b1)
        begin
            n_rise <= n_rise + 1;
            rise_t <= $time;
        end
        if (hs_gate === 1'b1)
            on_cnt <= on_cnt + 1;
        else if (on_cnt != 0)
        begin
            last_on <= on_cnt;
            on_cnt <= 0;
        end
        if (timing_sync_pin === 1'b0 && pin_q === 1'b1)
            fall_t <= $time;
        hs_q <= hs_gate;
        pin_q <= timing_sync_pin;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rdv = prdata;
        erv = pslverr;
        chk(pready, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for the next gate rise; gap gives rise-to-rise cycles
    task automatic wait_rise();
        int n0;
        n0 = n_rise;
        for (int k = 0; k < 3000 && n_rise == n0; k++)
            @(posedge pclk);
    endtask

    task automatic gap();
        time t0;
        wait_rise();
        t0 = rise_t;
        wait_rise();
        g = int'((rise_t - t0) / CLK_NS);
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task automatic t_regs();
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rdv[CTRL_RUN_BIT], CTRL_RUN_RST);
        apb(1'b0, PERIOD_OFS, 32'h0);
        chk(rdv, {16'h0000, PERIOD_RST});
        apb(1'b1, 8'h10, 32'hffffffff);
        chk(erv, 1);
        apb(1'b0, 8'h10, 32'h0);
        chk(erv, 1);
        chk(rdv, 32'h0);
        apb(1'b1, PERIOD_OFS, 32'h00000028);
        gap();
        gap();
        chk(g, 40);
        apb(1'b1, PERIOD_OFS, {16'h0000, PERIOD_RST});
    endtask

    // Every divide code, shortest pulse with the trip flag held high
    task automatic t_divide();
        logic [2:0] fq [4];
        fq = '{3'b111, 3'b011, 3'b001, 3'b000};
        for (int i = 0; i < 4; i++)
        begin
            fb_quarter <= fq[i];
            gap();
            gap();
            chk(g, PERIOD_RST * (1 << i));
            apb(1'b0, STATUS_OFS, 32'h0);
            chk(rdv[10:8], i);
            chk(last_on >= MIN_ON_CYC && last_on <= MIN_ON_CYC + 2, 1);
        end
        fb_quarter <= 3'b111;
    endtask

    task automatic t_limit();
        cur_trip <= 1'b0;
        wait_rise();
        repeat (10) @(negedge pclk);
        chk(hs_gate, 1);
        @(posedge pclk);
        ilim_trip <= 1'b1;
        repeat (4) @(negedge pclk);
        chk(hs_gate, 0);
        @(posedge pclk);
        ilim_trip <= 1'b0;
        cur_trip <= 1'b1;
    endtask

    task automatic t_ovp();
        int n0;
        logic [31:0] s0;
        apb(1'b0, SSCNT_OFS, 32'h0);
        s0 = rdv;
        overvoltage_guard <= 1'b1;
        repeat (4) @(posedge pclk);
        n0 = n_rise;
        repeat (300) @(posedge pclk);
        chk(n_rise == n0, 1);
        overvoltage_guard <= 1'b0;
        gap();
        gap();
        chk(g, PERIOD_RST);
        apb(1'b0, SSCNT_OFS, 32'h0);
        chk(rdv >= s0, 1);
        // Clock enable low freezes pulses and slow start
        ce <= 1'b0;
        repeat (2) @(posedge pclk);
        n0 = n_rise;
        s0 = 32'(ss_level);
        repeat (200) @(posedge pclk);
        chk({n_rise == n0, ss_level == s0[10:0]}, 2'b11);
        ce <= 1'b1;
    endtask

    // Stop by thermal trip (0), enable low (1) or run bit cleared (2)
    task automatic t_stop(input int which);
        int n0;
        if (which == 2)
            apb(1'b1, CTRL_OFS, 32'h0);
        @(posedge pclk);
        thermal_trip <= (which == 0);
        en_ok <= (which != 1);
        repeat (4) @(posedge pclk);
        n0 = n_rise;
        repeat (200) @(negedge pclk);
        chk(n_rise == n0, 1);
        chk(ss_level, 0);
        @(posedge pclk);
        thermal_trip <= 1'b0;
        en_ok <= 1'b1;
        if (which == 2)
            apb(1'b1, CTRL_OFS, 32'h1);
        gap();
        gap();
        @(negedge pclk);
        chk(ss_level != 0 && ss_level < 11'd8, 1);
    endtask

    task automatic t_sync();
        int k;
        @(posedge pclk);
        sync_half <= 8'd10;
        sync_run <= 1'b1;
        for (k = 0; k < 200 && src_en !== 1'b0; k++)
            @(negedge pclk);
        chk(src_en, 0);
        k = 0;
        do
        begin
            apb(1'b0, STATUS_OFS, 32'h0);
            k++;
        end
        while (rdv[ST_LOCK_BIT] !== 1'b1 && k < LOCK_CYC / 3);
        chk({rdv[ST_PLL_BIT], rdv[ST_LOCK_BIT]}, 2'b11);
        gap();
        gap();
        chk(g, 20);
        chk(rise_t >= fall_t && rise_t - fall_t <= 6 * CLK_NS, 1);
        for (k = 0; k < 40000 && ss_level !== SS_CYCLES; k++)
            @(negedge pclk);
        repeat (100) @(negedge pclk);
        chk(ss_level, SS_CYCLES);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rdv[ST_SSDONE_BIT], 1);
        fb_quarter <= 3'b000;
        gap();
        gap();
        chk(g, 160);
        fb_quarter <= 3'b111;
        sync_half <= 8'd30;
        gap();
        gap();
        chk(g, 60);
        sync_run <= 1'b0;
        k = 0;
        do
        begin
            apb(1'b0, STATUS_OFS, 32'h0);
            k++;
        end
        while (rdv[ST_FB_BIT] !== 1'b1 && k < 400);
        chk(rdv[ST_FB_BIT], 1);
        gap();
        chk(g, FB_PER_CYC);
        for (k = 0; k < 2000 && src_en !== 1'b1; k++)
            @(negedge pclk);
        chk(src_en, 1);
        gap();
        gap();
        chk(g, PERIOD_RST);
    endtask

    // -----------------------------------------------------------
    // Main sequence and watchdog
    // -----------------------------------------------------------
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ilim_trip, overvoltage_guard, thermal_trip, sync_run} = '0;
        {ce, cur_trip, en_ok} = 3'b111;
        fb_quarter = 3'b111;
        sync_half = 8'd10;
        {n_fail, n_tests, n_rise, on_cnt, last_on} = '0;
        {rise_t, fall_t} = '0;
        {hs_q, pin_q} = 2'b00;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_divide();
        t_limit();
        t_ovp();
        for (int i = 0; i < 3; i++)
            t_stop(i);
        t_sync();
        tally_and_finish();
    end

    // Whole run is well under this span; a hang counts as a mismatch
    initial
    begin
        repeat (90000) @(posedge pclk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule
